// *** src/line_codec_pkg.sv ***
package line_codec_pkg;

  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  // collision stays asserted this long after the last edge on the pair
  localparam int unsigned COL_HOLD_NS   = 200;
  localparam int unsigned COL_HOLD_CYC  = (COL_HOLD_NS / CLK_PERIOD_NS < 1) ?
                                          1 : COL_HOLD_NS / CLK_PERIOD_NS;
  localparam int unsigned COL_CNT_W     = 4;

  // end of frame: this many equal half-cell samples (1.5 bit times)
  localparam logic [1:0]  RX_END_HALVES = 2'h3;
  localparam logic [1:0]  RUN_ZERO      = 2'h0;
  localparam logic [1:0]  RUN_ONE       = 2'h1;

  // receive buffer geometry
  localparam int unsigned RX_FIFO_DEPTH = 32;

  // transmit line levels
  localparam logic        LINE_HIGH     = 1'b1;
  localparam logic        LINE_LOW      = 1'b0;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h1,
    TX_DATA = 3'h2,
    TX_TAIL = 3'h4
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'h1,
    RX_SYNC = 3'h2,
    RX_DATA = 3'h4
  } rx_state_t;

  // one entry of the receive buffer
  typedef struct packed {
    logic end_mark;
    logic data;
  } rx_item_t;

endpackage

// *** src/stream_fifo.sv ***
`timescale 1ns/100ps

module stream_fifo #(
  parameter int unsigned WIDTH = 2,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_ptr_q;
  logic [AW:0]      rd_ptr_q;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  // extra pointer bit tells full from empty
  assign empty       = (wr_ptr_q == rd_ptr_q);
  assign full        = (wr_ptr_q[AW] != rd_ptr_q[AW]) &&
                       (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign push        = in_valid_i && !full;
  assign pop         = out_ready_i && !empty;
  assign out_data_o  = mem_q[rd_ptr_q[AW-1:0]];

  // storage is written only, never reset
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q[AW-1:0]] <= in_data_i;
    end
  end

  // pointers
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

endmodule

// *** src/manchester_line_codec.sv ***
`timescale 1ns/100ps

module manchester_line_codec (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic osc_input_i,
  input  wire logic codec_bypass_select_i,
  input  wire logic idle_level_select_i,
  input  wire logic mac_tx_en_i,
  input  wire logic mac_tx_data_i,
  output logic      tx_bit_clock_o,
  output logic      tx_p_o,
  output logic      tx_n_o,
  input  wire logic rx_line_i,
  input  wire logic rx_squelch_ok_i,
  input  wire logic collision_line_pair_i,
  input  wire logic ext_rx_data_i,
  input  wire logic ext_rx_strobe_i,
  input  wire logic ext_carrier_i,
  input  wire logic ext_col_i,
  output logic      mac_carrier_o,
  output logic      mac_collision_o,
  output logic      mac_rx_valid_o,
  input  wire logic mac_rx_ready_i,
  output logic      mac_rx_data_o,
  output logic      mac_rx_end_o,
  output logic      rx_clock_o,
  output logic      rx_overflow_o,
  output logic      ser_tx_en_o,
  output logic      ser_tx_data_o,
  output logic      ser_rx_data_o,
  output logic      ser_carrier_o,
  output logic      ser_col_o
);

  line_codec_pkg::tx_state_t tx_state_q;
  line_codec_pkg::rx_state_t rx_state_q;
  line_codec_pkg::rx_item_t  push_item;
  line_codec_pkg::rx_item_t  pop_item;

  logic                                  half_q;
  logic                                  cell_start;
  logic                                  tx_go;
  logic                                  enc_q;
  logic                                  last_bit_q;
  logic                                  tx_p_q;
  logic                                  tx_n_q;
  logic                                  prev_q;
  logic                                  first_q;
  logic                                  phase_q;
  logic [1:0]                            run_q;
  logic                                  rx_s;
  logic                                  rx_tick;
  logic                                  end_hit;
  logic                                  bit_ev;
  logic                                  end_ev;
  logic                                  rx_clk_q;
  logic                                  carrier_q;
  logic                                  push_valid;
  logic                                  push_ready;
  logic                                  overflow_q;
  logic                                  col_prev_q;
  logic [line_codec_pkg::COL_CNT_W-1:0]  col_cnt_q;
  logic                                  col_q;
  logic                                  mac_carrier_q;
  logic                                  mac_col_q;
  logic                                  ser_tx_en_q;
  logic                                  ser_tx_data_q;
  logic                                  ser_rx_data_q;
  logic                                  ser_carrier_q;
  logic                                  ser_col_q;

  localparam logic [line_codec_pkg::COL_CNT_W-1:0] COL_LOAD =
    line_codec_pkg::COL_CNT_W'(line_codec_pkg::COL_HOLD_CYC);
  // each oscillator tick is one half cell; the bit clock toggles on it
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      half_q <= 1'b0;
    end else if (osc_input_i) begin
      half_q <= !half_q;
    end
  end

  assign tx_bit_clock_o = half_q;
  assign cell_start     = osc_input_i && !half_q;
  // bypass keeps the internal encoder quiet
  assign tx_go          = mac_tx_en_i && !codec_bypass_select_i;
  // encoder: inverted half then true half, rising tail after a final zero
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_state_q <= line_codec_pkg::TX_IDLE;
      enc_q      <= line_codec_pkg::LINE_HIGH;
      last_bit_q <= 1'b0;
    end else if (osc_input_i) begin
      unique case (tx_state_q)
        line_codec_pkg::TX_IDLE: begin
          if (cell_start && tx_go) begin
            tx_state_q <= line_codec_pkg::TX_DATA;
            enc_q      <= !mac_tx_data_i;
            last_bit_q <= mac_tx_data_i;
          end
        end
        line_codec_pkg::TX_DATA: begin
          if (!cell_start) begin
            enc_q <= last_bit_q;
          end else if (tx_go) begin
            enc_q      <= !mac_tx_data_i;
            last_bit_q <= mac_tx_data_i;
          end else if (!last_bit_q) begin
            tx_state_q <= line_codec_pkg::TX_TAIL;
            enc_q      <= line_codec_pkg::LINE_HIGH;
          end else begin
            tx_state_q <= line_codec_pkg::TX_IDLE;
          end
        end
        line_codec_pkg::TX_TAIL: begin
          if (cell_start) begin
            tx_state_q <= tx_go ? line_codec_pkg::TX_DATA : line_codec_pkg::TX_IDLE;
            enc_q      <= !mac_tx_data_i;
            last_bit_q <= mac_tx_data_i;
          end
        end
      endcase
    end
  end

  // line pair: idle level is fixed by the select pin, so no edges while idle
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_p_q <= line_codec_pkg::LINE_LOW;
      tx_n_q <= line_codec_pkg::LINE_LOW;
    end else if (tx_state_q == line_codec_pkg::TX_IDLE) begin
      tx_p_q <= !idle_level_select_i;
      tx_n_q <= line_codec_pkg::LINE_LOW;
    end else begin
      tx_p_q <= enc_q;
      tx_n_q <= !enc_q;
    end
  end

  assign tx_p_o = tx_p_q;
  assign tx_n_o = tx_n_q;
  // decoder samples the line once per half cell
  assign rx_tick = osc_input_i;
  assign rx_s    = rx_line_i;
  // a third equal half-cell sample means no mid-cell edge: frame over
  assign end_hit = (rx_s == prev_q) &&
                   (run_q == line_codec_pkg::RX_END_HALVES - 2'h2);
  assign bit_ev  = rx_tick && (rx_state_q == line_codec_pkg::RX_DATA) &&
                   rx_squelch_ok_i && phase_q && (rx_s != first_q);
  assign end_ev  = rx_tick && (rx_state_q == line_codec_pkg::RX_DATA) &&
                   (!rx_squelch_ok_i || end_hit);
  // decoder state: hunt for a mid-cell edge, then pair half cells
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_state_q <= line_codec_pkg::RX_IDLE;
      prev_q     <= 1'b0;
      first_q    <= 1'b0;
      phase_q    <= 1'b0;
      run_q      <= line_codec_pkg::RUN_ZERO;
    end else if (rx_tick) begin
      prev_q <= rx_s;
      if (rx_s != prev_q) begin
        run_q <= line_codec_pkg::RUN_ZERO;
      end else if (run_q != line_codec_pkg::RX_END_HALVES) begin
        run_q <= run_q + line_codec_pkg::RUN_ONE;
      end
      unique case (rx_state_q)
        line_codec_pkg::RX_IDLE: begin
          if (rx_squelch_ok_i) begin
            rx_state_q <= line_codec_pkg::RX_SYNC;
          end
        end
        line_codec_pkg::RX_SYNC: begin
          if (!rx_squelch_ok_i) begin
            rx_state_q <= line_codec_pkg::RX_IDLE;
          end else if (rx_s != prev_q) begin
            rx_state_q <= line_codec_pkg::RX_DATA;
            phase_q    <= 1'b0;
          end
        end
        line_codec_pkg::RX_DATA: begin
          if (!rx_squelch_ok_i || end_hit) begin
            rx_state_q <= line_codec_pkg::RX_IDLE;
          end else if (!phase_q) begin
            first_q <= rx_s;
            phase_q <= 1'b1;
          end else if (rx_s != first_q) begin
            phase_q <= 1'b0;
          end else begin
            first_q <= rx_s; // slip half a cell to realign
          end
        end
      endcase
    end
  end

  // recovered clock rises with each decoded bit, falls at the first half
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_clk_q <= 1'b0;
    end else if (bit_ev) begin
      rx_clk_q <= 1'b1;
    end else if (rx_tick && !phase_q) begin
      rx_clk_q <= 1'b0;
    end
  end

  // carrier follows qualified input until the frame end is seen
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      carrier_q <= 1'b0;
    end else if (rx_tick) begin
      if (rx_state_q == line_codec_pkg::RX_IDLE) begin
        carrier_q <= rx_squelch_ok_i;
      end else if (end_ev || !rx_squelch_ok_i) begin
        carrier_q <= 1'b0;
      end
    end
  end

  // buffer source: own decoder, or the external codec in bypass
  always_comb begin
    if (codec_bypass_select_i) begin
      push_valid         = ext_rx_strobe_i;
      push_item.data     = ext_rx_data_i;
      push_item.end_mark = 1'b0;
    end else begin
      push_valid         = bit_ev || end_ev;
      push_item.data     = rx_s;
      push_item.end_mark = end_ev;
    end
  end

  // the line cannot be stalled, so a full buffer drops and reports
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      overflow_q <= 1'b0;
    end else begin
      overflow_q <= push_valid && !push_ready;
    end
  end

  stream_fifo #(
    .WIDTH ($bits(line_codec_pkg::rx_item_t)),
    .DEPTH (line_codec_pkg::RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   (push_item),
    .out_valid_o (mac_rx_valid_o),
    .out_ready_i (mac_rx_ready_i),
    .out_data_o  (pop_item)
  );

  assign mac_rx_data_o = pop_item.data;
  assign mac_rx_end_o  = pop_item.end_mark;
  assign rx_clock_o    = rx_clk_q;
  assign rx_overflow_o = overflow_q;
  // any edge on the collision pair retriggers a hold timer; the
  // 10 MHz burst becomes one steady level
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      col_prev_q <= 1'b0;
      col_cnt_q  <= '0;
    end else begin
      col_prev_q <= collision_line_pair_i;
      if (collision_line_pair_i != col_prev_q) begin
        col_cnt_q <= COL_LOAD;
      end else if (col_cnt_q != '0) begin
        col_cnt_q <= col_cnt_q - 1'b1;
      end
    end
  end

  assign col_q = (col_cnt_q != '0);
  // MAC-facing status and observation copies
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mac_carrier_q <= 1'b0;
      mac_col_q     <= 1'b0;
      ser_tx_en_q   <= 1'b0;
      ser_tx_data_q <= 1'b0;
      ser_rx_data_q <= 1'b0;
      ser_carrier_q <= 1'b0;
      ser_col_q     <= 1'b0;
    end else begin
      // collision goes to the MAC, which aborts and reschedules
      mac_carrier_q <= codec_bypass_select_i ? ext_carrier_i : carrier_q;
      mac_col_q     <= codec_bypass_select_i ? ext_col_i : col_q;
      ser_tx_en_q   <= mac_tx_en_i;
      ser_tx_data_q <= mac_tx_data_i;
      ser_rx_data_q <= codec_bypass_select_i ? 1'b0 : rx_s;
      ser_carrier_q <= codec_bypass_select_i ? 1'b0 : carrier_q;
      ser_col_q     <= codec_bypass_select_i ? 1'b0 : col_q;
    end
  end

  assign mac_carrier_o   = mac_carrier_q;
  assign mac_collision_o = mac_col_q;
  assign ser_tx_en_o     = ser_tx_en_q;
  assign ser_tx_data_o   = ser_tx_data_q;
  assign ser_rx_data_o   = ser_rx_data_q;
  assign ser_carrier_o   = ser_carrier_q;
  assign ser_col_o       = ser_col_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  bypass_quiet_a: assert property (
    codec_bypass_select_i && cell_start &&
    tx_state_q == line_codec_pkg::TX_IDLE |=> tx_state_q == line_codec_pkg::TX_IDLE)
    else $error("encoder started while bypassed");
  mirror_copy_a: assert property (
    !codec_bypass_select_i |=> ser_carrier_o == $past(carrier_q) &&
    ser_tx_data_o == $past(mac_tx_data_i))
    else $error("observation copy mismatch");
  tx_start_a: assert property (
    cell_start && tx_go |=> tx_state_q == line_codec_pkg::TX_DATA &&
    enc_q == !$past(mac_tx_data_i))
    else $error("encoder did not start on send");
  mid_cell_a: assert property (
    osc_input_i && half_q && tx_state_q == line_codec_pkg::TX_DATA
    |=> enc_q != $past(enc_q))
    else $error("no mid-cell transition");
  tail_rise_a: assert property (
    tx_state_q == line_codec_pkg::TX_TAIL |-> enc_q == line_codec_pkg::LINE_HIGH)
    else $error("tail not high");
  idle_level_a: assert property (
    tx_state_q == line_codec_pkg::TX_IDLE ##1 tx_state_q == line_codec_pkg::TX_IDLE
    |-> tx_p_o == !$past(idle_level_select_i) && tx_n_o == line_codec_pkg::LINE_LOW)
    else $error("wrong idle level");
  squelch_gate_a: assert property (
    rx_state_q == line_codec_pkg::RX_IDLE && !rx_squelch_ok_i
    |=> rx_state_q == line_codec_pkg::RX_IDLE)
    else $error("decoder left idle unqualified");
  frame_end_a: assert property (
    rx_tick && rx_state_q == line_codec_pkg::RX_DATA && end_hit
    |=> rx_state_q == line_codec_pkg::RX_IDLE && !carrier_q)
    else $error("frame end missed");
  collision_a: assert property (
    collision_line_pair_i != col_prev_q && !codec_bypass_select_i
    |=> ##1 mac_collision_o [*3])
    else $error("collision not steady");
  divider_a: assert property (
    osc_input_i |=> tx_bit_clock_o != $past(tx_bit_clock_o))
    else $error("bit clock not halved");
  carrier_a: assert property (
    rx_state_q == line_codec_pkg::RX_DATA |-> carrier_q)
    else $error("carrier dropped mid frame");

endmodule

// *** tb/aui_xcvr_model.sv ***
`timescale 1ns/100ps
// far-side transceiver: receive line, squelch and collision pair
module aui_xcvr_model (
  input  wire logic clk_i,
  input  wire logic osc_input_i,
  output logic      rx_line_o,
  output logic      squelch_ok_o,
  output logic      col_pair_o
);
  logic seen_q = 1'b0, line_q = 1'b0, wander_q = 1'b0;
  logic sq_q = 1'b0, col_q = 1'b0, col_on = 1'b0;
  assign squelch_ok_o = sq_q;
  assign col_pair_o = col_q;
  // an unqualified line changes every clock so no stale level passes for data
  assign rx_line_o = sq_q ? line_q : wander_q;
  // line moves on the falling edge after a sampled tick, far from the next sample
  always @(posedge clk_i) seen_q <= osc_input_i;
  always @(negedge clk_i) wander_q <= ~wander_q;
  // an active pair toggles every clock, a quiet one holds still
  always @(negedge clk_i) if (col_on) col_q <= ~col_q;
  task automatic half(input logic v);
    do @(negedge clk_i); while (seen_q !== 1'b1);
    line_q = v;
  endtask
  // two low halves, bits lsb first (bit 0 set gives the sync edge), held tail
  task automatic send_frame(input logic [63:0] bits, input int n);
    half(1'b0);
    sq_q = 1'b1;
    half(1'b0);
    for (int k = 0; k < n; k++) begin
      half(~bits[k]);
      half(bits[k]);
    end
    repeat (3) half(bits[n-1]);
  endtask
  task automatic quiet();
    sq_q = 1'b0;
  endtask
  task automatic collide(input logic on);
    col_on = on;
  endtask
endmodule

// *** tb/tb_manchester_line_codec.sv ***
`timescale 1ns/100ps
module tb_manchester_line_codec;
  logic       clk_i = 1'b0, sys_rst_i = 1'b1, osc_input_i = 1'b0, mac_rx_ready_i = 1'b0;
  logic       codec_bypass_select_i = 1'b0, idle_level_select_i = 1'b0;
  logic       mac_tx_en_i = 1'b0, mac_tx_data_i = 1'b0, ext_rx_data_i = 1'b0;
  logic       ext_rx_strobe_i = 1'b0, ext_carrier_i = 1'b0, ext_col_i = 1'b0;
  logic       rx_line_i, rx_squelch_ok_i, collision_line_pair_i, rxc_q, rxl_q;
  logic       tx_bit_clock_o, tx_p_o, tx_n_o, mac_carrier_o, mac_collision_o;
  logic       mac_rx_valid_o, mac_rx_data_o, mac_rx_end_o, rx_clock_o, rx_overflow_o;
  logic       ser_tx_en_o, ser_tx_data_o, ser_rx_data_o, ser_carrier_o, ser_col_o;
  logic [1:0] div_q = 2'h0;
  int         err_total = 0, compares = 0, ovf_n = 0, rxclk_n = 0;
  manchester_line_codec manchester_line_codec_inst (
    .clk_i, .sys_rst_i, .osc_input_i, .codec_bypass_select_i, .idle_level_select_i,
    .mac_tx_en_i, .mac_tx_data_i, .tx_bit_clock_o, .tx_p_o, .tx_n_o, .rx_line_i,
    .rx_squelch_ok_i, .collision_line_pair_i, .ext_rx_data_i, .ext_rx_strobe_i,
    .ext_carrier_i, .ext_col_i, .mac_carrier_o, .mac_collision_o, .mac_rx_valid_o,
    .mac_rx_ready_i, .mac_rx_data_o, .mac_rx_end_o, .rx_clock_o, .rx_overflow_o,
    .ser_tx_en_o, .ser_tx_data_o, .ser_rx_data_o, .ser_carrier_o, .ser_col_o
  );
  aui_xcvr_model aui_xcvr_model_inst (
    .clk_i, .osc_input_i, .rx_line_o(rx_line_i), .squelch_ok_o(rx_squelch_ok_i),
    .col_pair_o(collision_line_pair_i)
  );
  always #20 clk_i = ~clk_i;
  // half-cell ticks one clock in four; a counter on the rising edge keeps the
  // bench's view of the next tick free of falling-edge races
  always @(posedge clk_i) div_q <= div_q + 2'h1;
  always @(negedge clk_i) osc_input_i <= (div_q == 2'h3);
  // count overflow pulses and rising edges of the recovered clock
  always @(posedge clk_i) begin
    rxc_q <= rx_clock_o;
    rxl_q <= rx_line_i; // line level as the design sampled it
    if (rx_overflow_o === 1'b1) ovf_n++;
    if (rx_clock_o === 1'b1 && rxc_q === 1'b0) rxclk_n++;
  end
  task automatic conclude();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic quit(input string what);
    err_total++;
    $display("BAD %s expected done seen timeout", what);
    conclude();
  endtask
  // take the buffer head with a one-clock ready, then a clock with ready low
  // so back-to-back pops never flip ready twice in one time step
  task automatic pop(output logic d, output logic e);
    int i;
    i = 0;
    while (mac_rx_valid_o !== 1'b1) begin
      @(negedge clk_i);
      i++;
      if (i > 300) quit("rx valid");
    end
    d = mac_rx_data_o;
    e = mac_rx_end_o;
    mac_rx_ready_i = 1'b1;
    @(negedge clk_i);
    mac_rx_ready_i = 1'b0;
    @(negedge clk_i);
  endtask
  // reset values, then both idle levels held with no transitions
  task automatic t_reset();
    chk("tx_p in reset", tx_p_o, 1'b0);
    chk("rx valid in reset", mac_rx_valid_o, 1'b0);
    chk("carrier in reset", mac_carrier_o, 1'b0);
    sys_rst_i = 1'b0;
    for (int s = 0; s < 2; s++) begin
      idle_level_select_i = s[0];
      for (int c = 0; c < 24; c++) begin
        @(negedge clk_i);
        if (c > 2) chk("idle tx_p", tx_p_o, ~s[0]);
        if (c > 2) chk("idle tx_n", tx_n_o, 1'b0);
      end
    end
  endtask
  // one byte lsb first: halves inverted then true, rising ending after a final zero, then idle
  task automatic t_tx(input logic [7:0] bits, input logic sel);
    int i;
    i = 0;
    idle_level_select_i = sel;
    do begin
      @(negedge clk_i);
      i++;
    end while (!(div_q == 2'h3 && tx_bit_clock_o === 1'b0) && i < 40);
    if (i >= 40) quit("cell start");
    for (int k = 0; k < 8; k++) begin
      mac_tx_en_i = 1'b1;
      mac_tx_data_i = bits[k];
      repeat (3) @(negedge clk_i);
      chk("first half tx_p", tx_p_o, ~bits[k]);
      chk("first half tx_n", tx_n_o, bits[k]);
      chk("bit clock high", tx_bit_clock_o, 1'b1);
      chk("tx data copy", ser_tx_data_o, bits[k]);
      repeat (4) @(negedge clk_i);
      chk("second half tx_p", tx_p_o, bits[k]);
      chk("bit clock low", tx_bit_clock_o, 1'b0);
      @(negedge clk_i);
    end
    mac_tx_en_i = 1'b0;
    repeat (3) @(negedge clk_i);
    chk("tail first half", tx_p_o, bits[7] ? ~sel : 1'b1);
    repeat (4) @(negedge clk_i);
    chk("tail second half", tx_p_o, bits[7] ? ~sel : 1'b1);
    repeat (8) @(negedge clk_i);
    chk("idle after frame", tx_p_o, ~sel);
    chk("tx en copy", ser_tx_en_o, 1'b0);
  endtask
  // frame from the far side: all bits but the sync bit reach the buffer, then
  // an end mark; a long frame with the reader stalled fills it to refusal
  task automatic t_rx(input logic [63:0] bits, input int n);
    logic d, e;
    ovf_n = 0;
    rxclk_n = 0;
    repeat (40) begin
      @(negedge clk_i);
      chk("carrier unqualified", mac_carrier_o, 1'b0);
      chk("valid unqualified", mac_rx_valid_o, 1'b0);
    end
    fork
      aui_xcvr_model_inst.send_frame(bits, n);
      begin
        repeat (40) @(negedge clk_i);
        chk("carrier in frame", mac_carrier_o, 1'b1);
        chk("carrier copy", ser_carrier_o, 1'b1);
      end
    join
    repeat (3) @(negedge clk_i);
    chk("carrier after end", mac_carrier_o, 1'b0);
    aui_xcvr_model_inst.quiet();
    chk("overflow seen", ovf_n != 0, n > 32);
    chk("rx clock edges", rxclk_n == n - 1, 1'b1);
    for (int j = 1; j <= n && j <= 32; j++) begin
      pop(d, e);
      chk("rx end mark", e, j == n);
      if (j < n) chk("rx data", d, bits[j]);
    end
    repeat (4) @(negedge clk_i);
    chk("buffer drained", mac_rx_valid_o, 1'b0);
  endtask
  // toggling pair gives a steady indication, released after the hold
  task automatic t_col();
    aui_xcvr_model_inst.collide(1'b1);
    repeat (4) @(negedge clk_i);
    repeat (20) begin
      @(negedge clk_i);
      chk("collision steady", mac_collision_o, 1'b1);
      chk("collision copy", ser_col_o, 1'b1);
      chk("rx line copy", ser_rx_data_o, rxl_q);
    end
    aui_xcvr_model_inst.collide(1'b0);
    repeat (10) @(negedge clk_i);
    chk("collision released", mac_collision_o, 1'b0);
  endtask
  // external codec: its signals reach the mac side, the encoder stays idle
  task automatic t_bypass();
    logic d, e;
    codec_bypass_select_i = 1'b1;
    ext_col_i = 1'b1;
    ext_carrier_i = 1'b1;
    mac_tx_en_i = 1'b1;
    ext_rx_data_i = 1'b1;
    ext_rx_strobe_i = 1'b1;
    @(negedge clk_i);
    ext_rx_data_i = 1'b0;
    @(negedge clk_i);
    ext_rx_strobe_i = 1'b0;
    repeat (16) begin
      @(negedge clk_i);
      chk("tx idle bypass", tx_p_o, ~idle_level_select_i);
    end
    chk("ext collision", mac_collision_o, 1'b1);
    chk("ext carrier", mac_carrier_o, 1'b1);
    chk("carrier copy bypass", ser_carrier_o, 1'b0);
    chk("rx copy bypass", ser_rx_data_o, 1'b0);
    chk("col copy bypass", ser_col_o, 1'b0);
    chk("tx en copy bypass", ser_tx_en_o, 1'b1);
    pop(d, e);
    chk("ext data first", d, 1'b1);
    pop(d, e);
    chk("ext data second", d, 1'b0);
    codec_bypass_select_i = 1'b0;
    ext_col_i = 1'b0;
    ext_carrier_i = 1'b0;
    mac_tx_en_i = 1'b0;
  endtask
  // main sequence
  initial begin
    repeat (20) @(negedge clk_i);
    t_reset();
    t_tx(8'h35, 1'b1);
    t_tx(8'hca, 1'b1);
    t_tx(8'h4d, 1'b0);
    t_rx(64'h0000_0000_0000_b5a5, 16);
    t_rx(64'h0000_00c3_9e5a_6b2d, 40);
    t_col();
    t_bypass();
    conclude();
  end
  // watchdog for a hang the bounded loops cannot see
  initial begin
    repeat (60000) @(posedge clk_i);
    quit("run length");
  end
endmodule
